// file: fcsfu_unit.sv
// Float compare and sign functional unit with sticky status word flags
`timescale 1ns/1ps
`default_nettype none
module fcsfu_unit (
  // Clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_n_i,
  // Issue from slot 3
  input  wire fcsfu_pkg::fcsfu_issue_type     issue_i,
  // Flag updates from other floating-point units in the same cycle
  input  wire logic [fcsfu_pkg::FLAG_W-1:0]   other_flags_i,
  // Explicit status word write
  input  wire logic                           status_write_i,
  input  wire logic [fcsfu_pkg::FLAG_W-1:0]   status_write_data_i,
  // Results
  output var  fcsfu_pkg::fcsfu_result_type    result_o,
  output logic [fcsfu_pkg::FLAG_W-1:0]        program_status_word_o
);

  // Timing: the issue word is decoded and classified in one combinational pass,
  // and result and status word land together on the next rising edge, so the
  // latency is one cycle and a new operation may follow every cycle.
  // Flag results never touch the status word; only the sign result feeds it.
  // A cleared guard hides the operation completely: no strobe, no flag.
  // Status bits are sticky: only an explicit status write lowers them, and a
  // set arriving in the same cycle as that write still wins.
  // Limitation: rounding and inexact flags are not modelled, since neither a
  // compare nor a sign extraction can round.
  // Limitation: a quiet NaN compare raises nothing, and signalling NaNs are
  // not told apart from quiet ones.

  // Decoded kind of the operation in the issue word
  typedef enum {
    KIND_NONE,
    KIND_NEQ_FLAGS,
    KIND_SIGN,
    KIND_SIGN_FLAGS
  } fcsfu_op_kind_type;

  // Field access keeps the bit positions in one place
  function automatic logic [fcsfu_pkg::EXP_W-1:0] exp_of(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    return v[fcsfu_pkg::EXP_MSB:fcsfu_pkg::EXP_LSB];
  endfunction

  function automatic logic [fcsfu_pkg::MANT_W-1:0] mant_of(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    return v[fcsfu_pkg::MANT_MSB:fcsfu_pkg::MANT_LSB];
  endfunction

  function automatic logic sign_of(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    return v[fcsfu_pkg::SIGN_BIT];
  endfunction

  function automatic logic [fcsfu_pkg::DATA_W-2:0] mag_of(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    return v[fcsfu_pkg::SIGN_BIT-1:fcsfu_pkg::MANT_LSB];
  endfunction

  // Classification of one single-precision operand
  function automatic logic is_denorm(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    logic exp_clear;
    logic mant_set;
    exp_clear = exp_of(v) == fcsfu_pkg::EXP_ZERO;
    mant_set  = mant_of(v) != fcsfu_pkg::MANT_ZERO;
    return exp_clear && mant_set;
  endfunction

  function automatic logic is_nan(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    logic exp_full;
    logic mant_set;
    exp_full = exp_of(v) == fcsfu_pkg::EXP_MAX;
    mant_set = mant_of(v) != fcsfu_pkg::MANT_ZERO;
    return exp_full && mant_set;
  endfunction

  function automatic logic is_true_zero(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    logic [fcsfu_pkg::DATA_W-2:0] mag;
    mag = mag_of(v);
    return mag == fcsfu_pkg::MAG_ZERO;
  endfunction

  // Denormals become a zero of the same sign before any comparison
  function automatic logic [fcsfu_pkg::DATA_W-1:0] flushed(
    input logic [fcsfu_pkg::DATA_W-1:0] v
  );
    logic [fcsfu_pkg::DATA_W-1:0] f;
    f = v;
    if (is_denorm(v)) begin
      f = {sign_of(v), fcsfu_pkg::MAG_ZERO};
    end
    return f;
  endfunction

  // Exception vector in the status word layout, shared by all flag results
  function automatic logic [fcsfu_pkg::FLAG_W-1:0] flag_vector(
    input logic flush,
    input logic invalid
  );
    logic [fcsfu_pkg::FLAG_W-1:0] f;
    f = '0;
    f[fcsfu_pkg::FLUSH_BIT]   = flush;
    f[fcsfu_pkg::INVALID_BIT] = invalid;
    return f;
  endfunction

  // Each status bit merges on its own; bits outside the mask always read zero
  function automatic logic merge_bit(
    input logic base,
    input logic other,
    input logic own,
    input logic keep
  );
    return keep && (base || other || own);
  endfunction

  // Unknown opcodes decode to no operation, so they never write
  function automatic fcsfu_op_kind_type op_kind(
    input logic [fcsfu_pkg::OPC_W-1:0] code
  );
    fcsfu_op_kind_type k;
    case (code)
      fcsfu_pkg::OPC_NEQ_FLAGS: begin
        k = KIND_NEQ_FLAGS;
      end
      fcsfu_pkg::OPC_SIGN: begin
        k = KIND_SIGN;
      end
      fcsfu_pkg::OPC_SIGN_FLAGS: begin
        k = KIND_SIGN_FLAGS;
      end
      default: begin
        k = KIND_NONE;
      end
    endcase
    return k;
  endfunction

  // Operand view
  logic [fcsfu_pkg::DATA_W-1:0] first_operand;
  logic [fcsfu_pkg::DATA_W-1:0] second_operand;
  logic [fcsfu_pkg::DATA_W-1:0] first_flushed;
  // Operand classification
  logic                         first_denorm;
  logic                         first_nan;
  logic                         first_zero;
  logic                         first_negative;
  logic                         second_denorm;
  // Decode
  fcsfu_op_kind_type            op_kind_now;
  logic                         guard_open;
  logic                         do_sign;
  // Per-operation results
  logic [fcsfu_pkg::DATA_W-1:0] sign_value;
  logic [fcsfu_pkg::FLAG_W-1:0] sign_raised;
  logic [fcsfu_pkg::FLAG_W-1:0] compare_raised;
  // Next register values
  logic                         next_write;
  logic [fcsfu_pkg::DATA_W-1:0] next_dest;
  logic [fcsfu_pkg::FLAG_W-1:0] own_flag_set;
  logic [fcsfu_pkg::FLAG_W-1:0] status_base;
  logic [fcsfu_pkg::FLAG_W-1:0] next_status;
  // Result registers
  logic                         write_pulse;
  logic [fcsfu_pkg::DATA_W-1:0] dest_hold;

  assign first_operand  = issue_i.first_source_register;
  assign second_operand = issue_i.second_source_register;
  assign first_flushed  = flushed(first_operand);

  // Classification is done once and shared by both sign opcodes
  assign first_denorm   = is_denorm(first_operand);
  assign first_nan      = is_nan(first_operand);
  assign first_zero     = is_true_zero(first_flushed);
  assign first_negative = sign_of(first_operand);
  assign second_denorm  = is_denorm(second_operand);

  // Guard bit 0 gates every write and every flag update this unit raises
  assign op_kind_now = op_kind(issue_i.opcode);
  assign guard_open  = issue_i.valid && issue_i.guard;
  assign do_sign     = guard_open && (op_kind_now == KIND_SIGN);

  // Quiet compares raise no invalid flag; one builder keeps sign flags identical
  assign sign_raised    = flag_vector(first_denorm, first_nan);
  assign compare_raised = flag_vector(first_denorm || second_denorm, 1'b0);

  // NaN has no sign, so it yields zero and raises invalid instead
  always_comb begin
    if (first_nan || first_zero) begin
      sign_value = fcsfu_pkg::RES_ZERO;
    end else if (first_negative) begin
      sign_value = fcsfu_pkg::RES_NEG;
    end else begin
      sign_value = fcsfu_pkg::RES_POS;
    end
  end

  // Only a known opcode under an open guard raises the write strobe
  always_comb begin
    next_write = 1'b0;
    case (op_kind_now)
      KIND_NEQ_FLAGS: begin
        next_write = guard_open;
      end
      KIND_SIGN: begin
        next_write = guard_open;
      end
      KIND_SIGN_FLAGS: begin
        next_write = guard_open;
      end
      default: begin
        next_write = 1'b0;
      end
    endcase
  end

  // Destination holds its old value unless an operation is taken
  always_comb begin
    next_dest = dest_hold;
    if (guard_open) begin
      case (op_kind_now)
        KIND_NEQ_FLAGS: begin
          next_dest = compare_raised;
        end
        KIND_SIGN: begin
          next_dest = sign_value;
        end
        KIND_SIGN_FLAGS: begin
          next_dest = sign_raised;
        end
        default: begin
          next_dest = dest_hold;
        end
      endcase
    end
  end

  // Flag opcodes never reach the status word; a refused sign adds nothing
  always_comb begin
    own_flag_set = '0;
    if (do_sign) begin
      own_flag_set = sign_raised;
    end
  end

  // A status write replaces the old value; sets in the same cycle still win
  always_comb begin
    status_base = program_status_word_o;
    if (status_write_i) begin
      status_base = status_write_data_i;
    end
  end

  // Per-bit merge of every source of a flag
  always_comb begin
    next_status = '0;
    for (int i = 0; i < fcsfu_pkg::FLAG_W; i++) begin
      next_status[i] = merge_bit(status_base[i], other_flags_i[i], own_flag_set[i],
                                 fcsfu_pkg::FLAG_MASK[i]);
    end
  end

  // Write strobe stands for exactly one cycle after the take
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_pulse <= 1'b0;
    end else begin
      write_pulse <= next_write;
    end
  end

  // Destination keeps its value until the next accepted operation
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dest_hold <= '0;
    end else begin
      dest_hold <= next_dest;
    end
  end

  // Sticky flags land on the same edge as the destination write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_status_word_o <= '0;
    end else begin
      program_status_word_o <= next_status;
    end
  end

  // Both fields come straight from their flip-flops
  assign result_o = '{write: write_pulse, dest_register: dest_hold};

endmodule
`default_nettype wire

// file: fcsfu_pkg.sv
// Constants and types shared by the float compare and sign unit
// Overview of operation
// - Opcode 151 compares two operands for inequality, writes only exception bits.
// - Flag results use the status word exception layout and never change it.
// - Opcode 151 flushes denormal operands to zero and sets the flush flag.
// - Guarded flag operations write the destination only when guard bit 0 is one.
// - Opcode 152 writes 0 for zero, 1 for positive, all ones for negative.
// - Opcode 152 treats a denormal as zero and sets the status flush flag.
// - Opcode 152 exceptions, such as invalid for NaN, set status word flags.
// - Status exception flags are sticky; only a status write clears them.
// - Status flags update in the same cycle the destination is written.
// - Concurrent status updates OR together with the previous flag values.
// - A guarded sign operation writes neither result nor flags when guard is zero.
// - Opcode 153 writes the exception bits a sign computation would raise.
// - Opcode 153 flushes a denormal operand to zero and sets the flush flag.
// - Opcode 153 returns exactly the flags opcode 152 would raise.
`default_nettype none
package fcsfu_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OPC_W  = 8;
  localparam int unsigned FLAG_W = 32;
  localparam logic [OPC_W-1:0] OPC_NEQ_FLAGS  = 8'h97;
  localparam logic [OPC_W-1:0] OPC_SIGN       = 8'h98;
  localparam logic [OPC_W-1:0] OPC_SIGN_FLAGS = 8'h99;
  localparam int unsigned FLUSH_BIT   = 5;
  localparam int unsigned INVALID_BIT = 4;
  localparam logic [FLAG_W-1:0] FLAG_MASK = 32'h0000007F;
  localparam logic [DATA_W-1:0] RES_ZERO  = 32'h00000000;
  localparam logic [DATA_W-1:0] RES_POS   = 32'h00000001;
  localparam logic [DATA_W-1:0] RES_NEG   = 32'hFFFFFFFF;
  localparam logic [7:0]  EXP_MAX  = 8'hFF;
  localparam logic [7:0]  EXP_ZERO = 8'h00;
  localparam logic [22:0] MANT_ZERO = 23'h000000;
  localparam int unsigned EXP_W    = 8;
  localparam int unsigned MANT_W   = 23;
  localparam int unsigned SIGN_BIT = 31;
  localparam int unsigned EXP_MSB  = 30;
  localparam int unsigned EXP_LSB  = 23;
  localparam int unsigned MANT_MSB = 22;
  localparam int unsigned MANT_LSB = 0;
  localparam logic [DATA_W-2:0] MAG_ZERO = 31'h00000000;

  typedef struct packed {
    logic              valid;
    logic [OPC_W-1:0]  opcode;
    logic              guard;
    logic [DATA_W-1:0] first_source_register;
    logic [DATA_W-1:0] second_source_register;
  } fcsfu_issue_type;

  typedef struct packed {
    logic              write;
    logic [DATA_W-1:0] dest_register;
  } fcsfu_result_type;
endpackage
`default_nettype wire

// file: fcsfu_issuer.sv
// Issue stage model: one slot 3 operation per cycle
`timescale 1ns/1ps
`default_nettype none
module fcsfu_issuer (
  // Operation fields
  input  wire logic                 en_i,
  input  wire logic                 guard_i,
  input  wire logic [7:0]           op_i,
  input  wire logic [63:0]          ops_i,
  // Issue word
  output var fcsfu_pkg::fcsfu_issue_type issue_o
);
  assign issue_o = {en_i, op_i, guard_i, ops_i};
endmodule
`default_nettype wire

// file: fcsfu_unit_asserts.sv
// Checker for the float compare and sign unit
`timescale 1ns/1ps
`default_nettype none
module fcsfu_asserts (
  // Watched ports
  input wire logic                        ref_clk_i,
  input wire logic                        rst_n_i,
  input wire fcsfu_pkg::fcsfu_issue_type  issue_i,
  input wire logic [31:0]                 other_flags_i,
  input wire logic                        status_write_i,
  input wire fcsfu_pkg::fcsfu_result_type result_o,
  input wire logic [31:0]                 program_status_word_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [31:0] s = issue_i.first_source_register;
  wire logic [31:0] p = program_status_word_o;
  wire logic dn = s[30:23] == 8'h00 && s[22:0] != 23'h0;
  wire logic nan = s[30:23] == 8'hFF && s[22:0] != 23'h0;
  sequence tk(op);
    issue_i.valid && issue_i.guard && issue_i.opcode == op;
  endsequence
  take_write_a: assert property (tk(8'h97) or tk(8'h99) |=> result_o.write)
    else $error("write missing");
  stray_write_a: assert property (!(issue_i.valid && issue_i.guard) |=> !result_o.write)
    else $error("stray write");
  sign_neg_a: assert property (tk(8'h98) ##0 (s[31] && s[30:23] != 8'h00 && !nan)
    |=> result_o.dest_register == 32'hFFFFFFFF) else $error("bad negative sign");
  sign_pos_a: assert property (tk(8'h98) ##0 (!s[31] && s[30:23] != 8'h00 && !nan)
    |=> result_o.dest_register == 32'h00000001) else $error("bad positive sign");
  sign_flags_a: assert property (tk(8'h99) ##0 nan |=> result_o.dest_register == 32'h10)
    else $error("bad sign flags");
  sign_flush_a: assert property (tk(8'h98) ##0 dn |=> !result_o.dest_register && p[5])
    else $error("bad denormal sign");
  nan_inv_a: assert property (tk(8'h98) ##0 nan |=> !result_o.dest_register && p[4])
    else $error("bad nan sign");
  sticky_flags_a: assert property (!status_write_i |=> (p & $past(p)) == $past(p))
    else $error("flag lost");
  merge_or_a: assert property (!status_write_i |=> (p | ($past(other_flags_i) & 32'h7F)) == p)
    else $error("flags not merged");
  flags_keep_a: assert property ((tk(8'h97) or tk(8'h99)) ##0 (!status_write_i && !other_flags_i)
    |=> $stable(p)) else $error("status changed");
endmodule
bind fcsfu_unit fcsfu_asserts fcsfu_asserts_i (.ref_clk_i, .rst_n_i, .issue_i, .other_flags_i,
  .status_write_i, .result_o, .program_status_word_o);
`default_nettype wire

// file: testbench.sv
// Random and corner stimulus bench for the float compare and sign unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, en, g, status_write_i, e_wr;
  logic [7:0] op;
  logic [31:0] a, b, other_flags_i, status_write_data_i, r, e_dst, e_psw, program_status_word_o;
  logic [31:0] seed = 32'hCD264FB5;
  logic [31:0] cv [8] = '{32'h40400000, 32'h0, 32'hBF800000, 32'h80800000,
    32'h80400000, 32'hFFFFFFFF, 32'hFF800000, 32'h00400000};
  int failures = 0, check_count = 0;
  fcsfu_pkg::fcsfu_issue_type issue_i;
  fcsfu_pkg::fcsfu_result_type result_o;
  always #12.5 ref_clk_i = ~ref_clk_i;
  fcsfu_issuer fcsfu_issuer_i (.en_i(en), .guard_i(g), .op_i(op), .ops_i({a, b}), .issue_o(issue_i));
  fcsfu_unit fcsfu_unit_i (.ref_clk_i, .rst_n_i, .issue_i, .other_flags_i, .status_write_i,
    .status_write_data_i, .result_o, .program_status_word_o);
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function logic [31:0] fl(input logic [31:0] v);
    if (v[22:0] == 23'h0) return 32'h0;
    return v[30:23] == 8'h00 ? 32'h20 : v[30:23] == 8'hFF ? 32'h10 : 32'h0;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {en, g, status_write_i, op, a, b, other_flags_i, status_write_data_i} = 139'h0;
    {e_wr, e_dst, e_psw} = 65'h0;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      chk("write", {31'h0, result_o.write}, {31'h0, e_wr});
      chk("dest", result_o.dest_register, e_dst);
      chk("status", program_status_word_o, e_psw);
      seed = xs(seed);
      r = seed;
      {en, g, status_write_i} = {r[0], r[1] | r[2], r[9:5] == 5'h0};
      op = 8'h97 + {6'h0, r[4:3]};
      a = r[12] ? cv[r[15:13]] : xs(r);
      b = r[16] ? cv[r[19:17]] : xs(~r);
      other_flags_i = r[22:20] == 3'h0 ? {25'h0, r[29:23]} : 32'h0;
      status_write_data_i = {25'h0, r[31:25]};
      e_wr = en && g && op != 8'h9A;
      // Sign of zero, denormal and NaN is 0; compare raises only the flush flag
      if (e_wr) e_dst = op == 8'h97 ? (fl(a) | fl(b)) & 32'h20 : op == 8'h9A - 8'h1 ? fl(a)
        : (fl(a) != 32'h0 || a[30:0] == 31'h0) ? 32'h0 : a[31] ? 32'hFFFFFFFF : 32'h1;
      e_psw = (status_write_i ? status_write_data_i : e_psw) | other_flags_i
        | (e_wr && op == 8'h98 ? fl(a) : 32'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
